// ---- dv/lpw_core_checker.sv ----
// Port-level assertions for the wake-up and vector selection block
`timescale 1ns/1ps
module lpw_core_checker
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  rst_pin_n,
   input wire logic                  irq_pin_n,
   input wire logic                  watchdog_timeout,
   input wire logic                  undervolt_trip,
   input wire lpw_pkg::lpw_irq_type  irq_req,
   input wire logic                  crystal_ref_tick,
   input wire logic                  cpu_reset,
   input wire logic                  vector_valid,
   input wire logic [15:0]           vector_addr,
   input wire logic                  int_mask,
   input wire lpw_pkg::lpw_gate_type gates,
   input wire lpw_pkg::lpw_mode_type mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================================
   // Shadow of control bits, mode history, recovery ticks
   logic        in_wait, in_stop, in_rec, was_wait, was_stop, was_rec;
   logic        osc_q, tben_q, short_recovery_select_q, wake;
   logic [3:0]  wake_hist;
   logic [12:0] ticks;
   assign in_wait = mode == lpw_pkg::LPW_WAIT;
   assign in_stop = mode == lpw_pkg::LPW_STOP;
   assign in_rec = mode == lpw_pkg::LPW_RECOVER;
   assign wake = !rst_pin_n || !irq_pin_n || watchdog_timeout || undervolt_trip
                 || irq_req.break_req || irq_req.keypad_req;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         {tben_q, osc_q, short_recovery_select_q} <= 3'b000;
         {was_wait, was_stop, was_rec} <= 3'b000;
         wake_hist <= 4'h0;
      end
      else
      begin
         if (psel && penable && pready && pwrite && paddr == 12'h000)
            {tben_q, osc_q, short_recovery_select_q} <= pwdata[4:2];
         {was_wait, was_stop, was_rec} <= {in_wait, in_stop, in_rec};
         wake_hist <= {wake_hist[2:0], wake};
      end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ticks <= 13'h0000;
      else if (!in_rec)
         ticks <= 13'h0000;
      else if (crystal_ref_tick)
         ticks <= ticks + 13'h0001;
   // ====================================
   // Assertions
   property p_reset_vec;
      cpu_reset |-> vector_addr == 16'hFFFE;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("reset exit without reset vector");
   property p_mask_reset;
      cpu_reset |=> int_mask;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask clear after reset exit");
   property p_mask_entry;
      (in_wait && was_wait) || (in_stop && was_stop) |-> !int_mask;
   endproperty
   a_mask_entry: assert property (p_mask_entry)
      else $error("mask set in low-power mode");
   property p_wait_gates;
      in_wait && was_wait |-> !gates.cpu_clk_en && gates.bus_clk_en && gates.spi_run
                              && gates.timer_run;
   endproperty
   a_wait_gates: assert property (p_wait_gates)
      else $error("wrong enables in wait");
   property p_stop_freeze;
      in_stop && was_stop |-> !gates.spi_run && !gates.timer_run && !gates.cpu_clk_en;
   endproperty
   a_stop_freeze: assert property (p_stop_freeze)
      else $error("peripheral running in stop");
   property p_stop_noosc;
      in_stop && was_stop && !osc_q |-> !gates.gen_clk_en && !gates.bus_clk_en
                                        && !gates.tbase_run;
   endproperty
   a_stop_noosc: assert property (p_stop_noosc)
      else $error("clocks running in stop without oscillator");
   property p_tb_block;
      psel && penable && pready && paddr == 12'h00C && mode != lpw_pkg::LPW_RUN |-> pslverr;
   endproperty
   a_tb_block: assert property (p_tb_block)
      else $error("timebase reachable outside run");
   property p_wait_wake;
      in_wait && irq_req != 15'h0000 |-> ##[1:3] vector_valid;
   endproperty
   a_wait_wake: assert property (p_wait_wake)
      else $error("request did not end wait");
   property p_reset_wins;
      in_wait && undervolt_trip |-> ##[1:3] (vector_valid && vector_addr == 16'hFFFE);
   endproperty
   a_reset_wins: assert property (p_reset_wins)
      else $error("interrupt beat reset");
   property p_rec_len;
      was_rec && !in_rec |-> (short_recovery_select_q ? ticks inside {[31:33]} : ticks inside {[4095:4097]});
   endproperty
   a_rec_len: assert property (p_rec_len)
      else $error("wrong stop recovery length");
   property p_stop_hold;
      in_stop && !wake && wake_hist == 4'h0 && !(osc_q && tben_q) |=> in_stop;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop ended without a stop wake event");
endmodule

bind lpw_core lpw_core_checker i_chk (.*);

// ---- dv/lpw_core_tb.sv ----
// Self-checking bench for the wake-up and vector selection block
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      cmp_count++; \
      if ((a) !== (b)) \
      begin \
         num_errors++; \
         $display("Error at %0t: got %h, expected %h", $time, a, b); \
      end \
   end
module lpw_core_tb;
   logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, apb_err;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata, rd_data;
   logic                  rst_pin_n, irq_pin_n, watchdog_timeout, undervolt_trip;
   logic                  crystal_ref_tick, cpu_reset, vector_valid, int_mask, watch;
   logic [15:0]           vector_addr;
   lpw_pkg::lpw_irq_type  irq_req, raise;
   lpw_pkg::lpw_gate_type gates;
   lpw_pkg::lpw_mode_type mode;
   logic [16:0]           exp_q[$];
   logic [16:0]           exp_v;
   logic [15:0]           vec_tab[15];
   int                    num_errors, cmp_count, seed;

   lpw_core i_dut (.*);
   lpw_src_model i_src (.pclk(pclk), .presetn(presetn), .raise(raise),
      .vector_valid(vector_valid), .irq_req(irq_req), .crystal_ref_tick(crystal_ref_tick));

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ====================================
   // Tasks
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic hang;
      num_errors++;
      $display("Error at %0t: wait limit reached", $time);
      summarize;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 20)
         hang;
      apb_err = pslverr;
      rd_data = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_mode(input lpw_pkg::lpw_mode_type m);
      int n;
      n = 0;
      while (mode !== m && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 100)
         hang;
   endtask
   task automatic sleep(input logic [4:0] c);
      apb(1'b1, 12'h000, ($random(seed) & 32'hFFFF_FF00) | {27'h000_0000, c});
      wait_mode(c[1] ? lpw_pkg::LPW_STOP : lpw_pkg::LPW_WAIT);
      tick(2);
      `CHK(int_mask, 1'b0)
   endtask
   task automatic drain;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 20000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 20000)
         hang;
   endtask
   // ====================================
   // Vector monitor against the expected queue
   always @(posedge pclk)
      if (watch && vector_valid === 1'b1)
      begin
         exp_v = (exp_q.size() == 0) ? 17'h0_0000 : exp_q.pop_front();
         `CHK(vector_addr, exp_v[15:0])
         `CHK(cpu_reset, exp_v[16])
      end
   // ====================================
   // Main sequence
   initial
   begin
      seed = 32'h92f5_3e12;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rst_pin_n, irq_pin_n, watchdog_timeout, undervolt_trip, watch} = 5'b11000;
      raise = '0;
      num_errors = 0;
      cmp_count = 0;
      vec_tab = '{16'hFFFC, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE,
         16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE};
      presetn = 1'b0;
      tick(4);
      presetn <= 1'b1;
      tick(3);
      `CHK(int_mask, 1'b1)
      watch = 1'b1;
      // Each peripheral request ends wait with its own vector
      for (int i = 0; i < 15; i++)
      begin
         sleep(5'b00001);
         tick(($random(seed) & 3) + 1);
         exp_q.push_back({1'b0, vec_tab[i]});
         raise <= lpw_pkg::lpw_irq_type'(15'h4000 >> i);
         tick(1);
         raise <= '0;
         drain;
      end
      // Pin falling edge ends wait
      sleep(5'b00001);
      exp_q.push_back({1'b0, 16'hFFFA});
      irq_pin_n <= 1'b0;
      drain;
      irq_pin_n <= 1'b1;
      // Pin, watchdog and undervoltage resets end wait
      for (int k = 0; k < 3; k++)
      begin
         sleep(5'b00001);
         exp_q.push_back({1'b1, 16'hFFFE});
         {rst_pin_n, watchdog_timeout, undervolt_trip} <= {k != 0, k == 1, k == 2};
         drain;
         {rst_pin_n, watchdog_timeout, undervolt_trip} <= 3'b100;
         tick(4);
         `CHK(int_mask, 1'b1)
      end
      // Reset and interrupt together; timebase open in run, blocked in wait
      apb(1'b0, 12'h00C, 32'h0000_0000);
      `CHK(apb_err, 1'b0)
      sleep(5'b00001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      `CHK(apb_err, 1'b1)
      exp_q.push_back({1'b1, 16'hFFFE});
      raise <= lpw_pkg::lpw_irq_type'(15'h0010);
      undervolt_trip <= 1'b1;
      tick(1);
      raise <= '0;
      drain;
      undervolt_trip <= 1'b0;
      tick(4);
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK(rd_data, 32'h0000_FFFE)
      // Stop ignores timer, clock generator and serial requests, pin reset ends it
      sleep(5'b00110);
      raise <= lpw_pkg::lpw_irq_type'(15'h3004);
      tick(1);
      raise <= '0;
      tick(60);
      `CHK(mode, lpw_pkg::LPW_STOP)
      exp_q.push_back({1'b1, 16'hFFFE});
      rst_pin_n <= 1'b0;
      drain;
      rst_pin_n <= 1'b1;
      tick(4);
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK(rd_data, 32'h0000_0004)
      // Stop wake by pin, keypad (full recovery) and break
      for (int k = 0; k < 3; k++)
      begin
         sleep({2'b00, k != 1, 2'b10});
         apb(1'b0, 12'h00C, 32'h0000_0000);
         `CHK(apb_err, 1'b1)
         exp_q.push_back({1'b0, k == 0 ? 16'hFFFA : k == 1 ? 16'hFFE0 : 16'hFFFC});
         irq_pin_n <= (k != 0);
         raise <= lpw_pkg::lpw_irq_type'(k == 1 ? 15'h0002 : k == 2 ? 15'h4000 : 15'h0000);
         tick(1);
         raise <= '0;
         drain;
         irq_pin_n <= 1'b1;
      end
      // Timebase rollover wakes stop when the oscillator runs
      sleep(5'b11110);
      exp_q.push_back({1'b0, 16'hFFDC});
      drain;
      tick(4);
      summarize;
   end
endmodule

// ---- dv/lpw_src_model.sv ----
// Interrupt source and crystal reference model facing the wake-up block
`timescale 1ns/1ps
module lpw_src_model
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire lpw_pkg::lpw_irq_type raise,
   input  wire logic                 vector_valid,
   output lpw_pkg::lpw_irq_type      irq_req,
   output logic                      crystal_ref_tick
);
   // Requests held until the CPU takes a vector
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq_req <= '0;
      else if (vector_valid)
         irq_req <= raise;
      else
         irq_req <= irq_req | raise;
   // Free-running crystal reference at half the bus clock
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         crystal_ref_tick <= 1'b0;
      else
         crystal_ref_tick <= !crystal_ref_tick;
endmodule

// ---- src/lpw_consts.svh ----
// Constants for the low-power wake-up and vector selection block
// Contract
// - Serial peripheral runs in wait, wakes CPU
// - Stop halts serial peripheral; reset exit aborts
// - Timers run in wait, interrupts wake
// - Stop freezes timers; resume after interrupt exit
// - Timebase runs in wait, register blocked
// - Timebase runs in stop only with oscillator
// - Wait exit restarts CPU clock, loads vector
// - Pin, watchdog, undervoltage reset use reset vector
// - External interrupt falling edge vectors FFFA
// - Break wakes either mode, vectors FFFC
// - Clock generator interrupt vectors FFF8
// - Keypad interrupt vectors FFE0, edges in stop
// - Timer one vectors FFF2, FFF4, FFF6
// - Timer two vectors FFEC, FFEE, FFF0
// - Serial peripheral vectors FFE8, FFEA
// - Async serial vectors FFE2, FFE4, FFE6
// - Timebase vectors FFDC, rollover wakes stop
// - Only listed events may end stop
// - Stop recovery holds clocks 4096 crystal cycles
// - Short recovery select shortens to 32 cycles
// - Stop without oscillator holds generator clocks low
// - Entry clears mask; reset exit sets it
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH

`define LPW_VEC_RESET    16'hFFFE
`define LPW_VEC_BREAK    16'hFFFC
`define LPW_VEC_EXTIRQ   16'hFFFA
`define LPW_VEC_CLKGEN   16'hFFF8
`define LPW_VEC_T1CH0    16'hFFF6
`define LPW_VEC_T1CH1    16'hFFF4
`define LPW_VEC_T1OVF    16'hFFF2
`define LPW_VEC_T2CH0    16'hFFF0
`define LPW_VEC_T2CH1    16'hFFEE
`define LPW_VEC_T2OVF    16'hFFEC
`define LPW_VEC_SPIRX    16'hFFEA
`define LPW_VEC_SPITX    16'hFFE8
`define LPW_VEC_ASERR    16'hFFE6
`define LPW_VEC_ASRX     16'hFFE4
`define LPW_VEC_ASTX     16'hFFE2
`define LPW_VEC_KEYPAD   16'hFFE0
`define LPW_VEC_CONV     16'hFFDE
`define LPW_VEC_TBASE    16'hFFDC

`define LPW_REC_LONG     12'hFFF
`define LPW_REC_SHORT    12'h01F

`define LPW_ADDR_CTRL    12'h000
`define LPW_ADDR_STAT    12'h004
`define LPW_ADDR_VEC     12'h008
`define LPW_ADDR_TBASE   12'h00C

`define LPW_CTRL_WAIT    0
`define LPW_CTRL_STOP    1
`define LPW_CTRL_SHORT_RECOVERY_SELECT   2
`define LPW_CTRL_OSCSTOP 3
`define LPW_CTRL_TBEN    4

`define LPW_TB_DIV       16'h00FF
`define LPW_TB_FLAG      16

`endif

// ---- src/lpw_core.sv ----
// Low-power wake-up, recovery counting and vector selection
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lpw_consts.svh"

module lpw_core
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Wake sources
   input  wire logic                rst_pin_n,
   input  wire logic                irq_pin_n,
   input  wire logic                watchdog_timeout,
   input  wire logic                undervolt_trip,
   input  wire lpw_pkg::lpw_irq_type irq_req,
   input  wire logic                crystal_ref_tick,
   // To the CPU core
   output logic                     cpu_reset,
   output logic                     vector_valid,
   output logic [15:0]              vector_addr,
   output logic                     int_mask,
   output lpw_pkg::lpw_gate_type    gates,
   output lpw_pkg::lpw_mode_type    mode
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [1:0] rst_sync_reg;
   logic [1:0] irq_sync_reg;
   logic       irq_last_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_sync_reg <= 2'h3;
         irq_sync_reg <= 2'h3;
         irq_last_reg <= 1'b1;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], rst_pin_n};
         irq_sync_reg <= {irq_sync_reg[0], irq_pin_n};
         irq_last_reg <= irq_sync_reg[1];
      end
   end

   logic irq_fall;
   assign irq_fall = irq_last_reg & ~irq_sync_reg[1];

   // ==========================================================
   // Registers
   // ==========================================================
   logic [4:0]  ctrl_reg;
   logic [15:0] tbase_cnt_reg;
   logic        tbase_flag_reg;
   logic [15:0] vec_reg;
   logic        vec_valid_reg;
   logic        rst_exit_reg;
   logic        mask_reg;
   logic [11:0] rec_cnt_reg;
   lpw_pkg::lpw_mode_type mode_reg;
   logic        in_wait;
   logic        in_stop;
   logic        apb_wr;
   logic        addr_ok;
   logic        tb_blocked;

   assign in_wait = (mode_reg == lpw_pkg::LPW_WAIT);
   assign in_stop = (mode_reg == lpw_pkg::LPW_STOP) || (mode_reg == lpw_pkg::LPW_RECOVER);
   // Timebase register hidden while asleep
   assign tb_blocked = in_wait | in_stop;
   assign addr_ok = (paddr == `LPW_ADDR_CTRL) || (paddr == `LPW_ADDR_STAT) ||
                    (paddr == `LPW_ADDR_VEC)  ||
                    ((paddr == `LPW_ADDR_TBASE) && !tb_blocked);
   assign apb_wr = psel & penable & pwrite & addr_ok;

   // ==========================================================
   // Reset and wake sources
   // ==========================================================
   logic reset_src;
   logic any_int;
   logic stop_wake_int;
   logic tb_roll;

   assign reset_src = ~rst_sync_reg[1] | watchdog_timeout | undervolt_trip;
   assign any_int = irq_fall | (|irq_req) | tbase_flag_reg;
   // Stop ends only on reset, pin interrupt, keypad, break or timebase
   assign stop_wake_int = irq_fall | irq_req.keypad_req | irq_req.break_req |
                          tbase_flag_reg;

   // ==========================================================
   // Vector selection, fixed priority
   // ==========================================================
   logic [15:0] int_vec;
   // Break first, then pin, then peripherals

   always_comb
   begin
      if (irq_req.break_req)
         int_vec = `LPW_VEC_BREAK;
      else if (irq_fall)
         int_vec = `LPW_VEC_EXTIRQ;
      else if (irq_req.clkgen_req)
         int_vec = `LPW_VEC_CLKGEN;
      else if (irq_req.t1_ch0)
         int_vec = `LPW_VEC_T1CH0;
      else if (irq_req.t1_ch1)
         int_vec = `LPW_VEC_T1CH1;
      else if (irq_req.t1_ovf)
         int_vec = `LPW_VEC_T1OVF;
      else if (irq_req.t2_ch0)
         int_vec = `LPW_VEC_T2CH0;
      else if (irq_req.t2_ch1)
         int_vec = `LPW_VEC_T2CH1;
      else if (irq_req.t2_ovf)
         int_vec = `LPW_VEC_T2OVF;
      else if (irq_req.spi_rx)
         int_vec = `LPW_VEC_SPIRX;
      else if (irq_req.spi_tx)
         int_vec = `LPW_VEC_SPITX;
      else if (irq_req.as_err)
         int_vec = `LPW_VEC_ASERR;
      else if (irq_req.as_rx)
         int_vec = `LPW_VEC_ASRX;
      else if (irq_req.as_tx)
         int_vec = `LPW_VEC_ASTX;
      else if (irq_req.keypad_req)
         int_vec = `LPW_VEC_KEYPAD;
      else if (irq_req.conv_done)
         int_vec = `LPW_VEC_CONV;
      else
         int_vec = `LPW_VEC_TBASE;
   end

   // ==========================================================
   // Mode machine
   // ==========================================================
   logic        wake;
   logic        wake_rst;

   always_comb
   begin
      wake = 1'b0;
      wake_rst = 1'b0;
      unique case (mode_reg)
         lpw_pkg::LPW_RUN:
         begin
            wake = 1'b0;
         end
         lpw_pkg::LPW_WAIT:
         begin
            wake_rst = reset_src;
            wake = reset_src | any_int;
         end
         lpw_pkg::LPW_STOP:
         begin
            wake_rst = reset_src;
            wake = reset_src | stop_wake_int;
         end
         lpw_pkg::LPW_RECOVER:
         begin
            wake = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg     <= lpw_pkg::LPW_RUN;
         rec_cnt_reg  <= 12'h000;
         rst_exit_reg <= 1'b0;
      end
      else
      begin
         unique case (mode_reg)
            lpw_pkg::LPW_RUN:
            begin
               if (apb_wr && (paddr == `LPW_ADDR_CTRL) && pwdata[`LPW_CTRL_STOP])
                  mode_reg <= lpw_pkg::LPW_STOP;
               else if (apb_wr && (paddr == `LPW_ADDR_CTRL) && pwdata[`LPW_CTRL_WAIT])
                  mode_reg <= lpw_pkg::LPW_WAIT;
            end
            lpw_pkg::LPW_WAIT:
            begin
               if (wake)
                  mode_reg <= lpw_pkg::LPW_RUN;
            end
            lpw_pkg::LPW_STOP:
            begin
               if (wake)
               begin
                  mode_reg     <= lpw_pkg::LPW_RECOVER;
                  // Reset exit remembered until recovery ends
                  rst_exit_reg <= wake_rst;
                  rec_cnt_reg  <= ctrl_reg[`LPW_CTRL_SHORT_RECOVERY_SELECT] ?
                                  `LPW_REC_SHORT : `LPW_REC_LONG;
               end
            end
            lpw_pkg::LPW_RECOVER:
            begin
               if (crystal_ref_tick)
               begin
                  if (rec_cnt_reg == 12'h000)
                     mode_reg <= lpw_pkg::LPW_RUN;
                  else
                     rec_cnt_reg <= rec_cnt_reg - 12'h001;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Vector, reset and mask outputs
   // ==========================================================
   // Last recovery tick releases the CPU
   logic rec_done;
   assign rec_done = (mode_reg == lpw_pkg::LPW_RECOVER) && crystal_ref_tick &&
                     (rec_cnt_reg == 12'h000);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vec_reg       <= `LPW_VEC_RESET;
         vec_valid_reg <= 1'b0;
         cpu_reset     <= 1'b0;
         mask_reg      <= 1'b1;
      end
      else
      begin
         vec_valid_reg <= 1'b0;
         cpu_reset     <= 1'b0;
         if (apb_wr && (paddr == `LPW_ADDR_CTRL) && (mode_reg == lpw_pkg::LPW_RUN) &&
             (pwdata[`LPW_CTRL_STOP] | pwdata[`LPW_CTRL_WAIT]))
            mask_reg <= 1'b0;
         if (in_wait && wake)
         begin
            vec_valid_reg <= 1'b1;
            cpu_reset     <= wake_rst;
            vec_reg       <= wake_rst ? `LPW_VEC_RESET : int_vec;
            if (wake_rst)
               mask_reg <= 1'b1;
         end
         // Vector chosen at wake, shown after recovery
         else if ((mode_reg == lpw_pkg::LPW_STOP) && wake)
            vec_reg <= wake_rst ? `LPW_VEC_RESET : int_vec;
         else if (rec_done)
         begin
            vec_valid_reg <= 1'b1;
            cpu_reset     <= rst_exit_reg;
            if (rst_exit_reg)
               mask_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Timebase counter and rollover flag
   // ==========================================================
   logic tb_runs;
   assign tb_runs = ctrl_reg[`LPW_CTRL_TBEN] &&
                    (!in_stop || ctrl_reg[`LPW_CTRL_OSCSTOP]);
   assign tb_roll = tb_runs && crystal_ref_tick && (tbase_cnt_reg == `LPW_TB_DIV);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tbase_cnt_reg <= 16'h0000;
      else if (tb_runs && crystal_ref_tick)
         tbase_cnt_reg <= tb_roll ? 16'h0000 : tbase_cnt_reg + 16'h0001;
   end

   // Set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tbase_flag_reg <= 1'b0;
      else if (tb_roll)
         tbase_flag_reg <= 1'b1;
      else if (apb_wr && (paddr == `LPW_ADDR_TBASE) && pwdata[`LPW_TB_FLAG])
         tbase_flag_reg <= 1'b0;
   end

   // ==========================================================
   // Control register
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= 5'h00;
      else if (apb_wr && (paddr == `LPW_ADDR_CTRL))
         // Command bits self-clear, only options are kept
         ctrl_reg <= {pwdata[`LPW_CTRL_TBEN], pwdata[`LPW_CTRL_OSCSTOP],
                      pwdata[`LPW_CTRL_SHORT_RECOVERY_SELECT], 2'h0};
   end

   // ==========================================================
   // Clock and run gates
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gates <= '0;
      else
      begin
         // CPU and generator clocks stay off through recovery
         gates.cpu_clk_en <= (mode_reg == lpw_pkg::LPW_RUN) && !wake_next_stop();
         gates.bus_clk_en <= !in_stop || ctrl_reg[`LPW_CTRL_OSCSTOP];
         gates.gen_clk_en <= (mode_reg != lpw_pkg::LPW_RECOVER) &&
                             (!in_stop || ctrl_reg[`LPW_CTRL_OSCSTOP]);
         gates.spi_run    <= !in_stop;
         gates.spi_abort  <= (mode_reg == lpw_pkg::LPW_STOP) && wake_rst;
         gates.timer_run  <= !in_stop;
         gates.tbase_run  <= tb_runs;
      end
   end

   function automatic logic wake_next_stop();
      wake_next_stop = 1'b0;
   endfunction

   // ==========================================================
   // APB slave, zero wait states
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         // Blocked or unmapped access answers with an error
         pslverr <= psel & ~penable & ~addr_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite && addr_ok)
         begin
            unique case (paddr)
               `LPW_ADDR_CTRL:  prdata <= {27'h000_0000, ctrl_reg};
               `LPW_ADDR_STAT:  prdata <= {16'h0000, rec_cnt_reg, 1'b0, mask_reg,
                                           mode_reg};
               `LPW_ADDR_VEC:   prdata <= {16'h0000, vec_reg};
               default:         prdata <= {15'h0000, tbase_flag_reg, tbase_cnt_reg};
            endcase
         end
      end
   end

   assign vector_valid = vec_valid_reg;
   assign vector_addr  = vec_reg;
   assign int_mask     = mask_reg;
   assign mode         = mode_reg;

endmodule

// ---- src/lpw_pkg.sv ----
// Types for the low-power wake-up and vector selection block
package lpw_pkg;

   typedef enum logic [1:0] {
      LPW_RUN,
      LPW_WAIT,
      LPW_STOP,
      LPW_RECOVER
   } lpw_mode_type;

   // Interrupt requests from the peripherals, level active high
   typedef struct packed {
      logic break_req;
      logic clkgen_req;
      logic t1_ch0;
      logic t1_ch1;
      logic t1_ovf;
      logic t2_ch0;
      logic t2_ch1;
      logic t2_ovf;
      logic spi_rx;
      logic spi_tx;
      logic as_err;
      logic as_rx;
      logic as_tx;
      logic keypad_req;
      logic conv_done;
   } lpw_irq_type;

   // Clock and run enables towards the rest of the device
   typedef struct packed {
      logic cpu_clk_en;
      logic bus_clk_en;
      logic gen_clk_en;
      logic spi_run;
      logic spi_abort;
      logic timer_run;
      logic tbase_run;
   } lpw_gate_type;

endpackage
